// ### design/vintc_pkg.sv
// Constants for the vectored interrupt unit: register map, field layout,
// reset values and channel assignment.
// Assumes a single AHB-Lite slave select and word-only accesses.
//------------------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------------------
// Notes on behaviour
// - Software sorts each line into one class
// - Fast class highest, merged into one line
// - Readable word of active fast sources
// - Sixteen vectored slots, any line each
// - Lower slot number wins arbitration
// - Vectored above non-vectored, fast above both
// - Normal line asserts on any enabled normal-class request
// - Vector address gives winning slot's handler
// - No vectored winner gives default address
// - Status word of active normal requests
// - Channels 0 to 3: watchdog, software, debug
// - Channels 4, 5: timer match and capture
// - Channels 6, 7: serial port flag groups
// - Channel 7 also carries modem status
// - Channel 8 modulator, channel 9 two-wire bus
// - Channel 10: both synchronous serial ports
// - Channels 14 to 16: external inputs
package vintc_pkg;

  //----------------------------------------------------------------------
  // Sizes
  //----------------------------------------------------------------------
  localparam int NUM_SRC = 32;
  localparam int NUM_SLOT = 16;
  localparam int SLOT_W = 4;
  localparam int SRC_W = 5;
  localparam int AW = 12;

  //----------------------------------------------------------------------
  // Register byte offsets
  //----------------------------------------------------------------------
  localparam logic [11:0] OFS_NORM_STAT = 12'h000;
  localparam logic [11:0] OFS_FAST_STAT = 12'h004;
  localparam logic [11:0] OFS_RAW_STAT = 12'h008;
  localparam logic [11:0] OFS_CLASS = 12'h00c;
  localparam logic [11:0] OFS_ENABLE = 12'h010;
  localparam logic [11:0] OFS_SOFT = 12'h014;
  localparam logic [11:0] OFS_VECT = 12'h018;
  localparam logic [11:0] OFS_DEFAULT = 12'h01c;
  localparam logic [3:0] PAGE_SLOT_ADDR = 4'h1;
  localparam logic [3:0] PAGE_SLOT_CTRL = 4'h2;

  //----------------------------------------------------------------------
  // Slot control fields and reset values
  //----------------------------------------------------------------------
  localparam int CTRL_EN_BIT = 5;
  localparam int CTRL_SRC_LSB = 0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  //----------------------------------------------------------------------
  // Channel numbers
  //----------------------------------------------------------------------
  localparam int CH_WDOG = 0;
  localparam int CH_SOFT = 1;
  localparam int CH_DBG_RX = 2;
  localparam int CH_DBG_TX = 3;
  localparam int CH_TIMER0 = 4;
  localparam int CH_TIMER1 = 5;
  localparam int CH_UART0 = 6;
  localparam int CH_UART1 = 7;
  localparam int CH_PWM = 8;
  localparam int CH_TWI = 9;
  localparam int CH_SSER = 10;
  localparam int CH_RSVD = 11;
  localparam int CH_PLL = 12;
  localparam int CH_RTC = 13;
  localparam int CH_EXT0 = 14;
  localparam int CH_EXT1 = 15;
  localparam int CH_EXT2 = 16;

  //----------------------------------------------------------------------
  // AHB encodings
  //----------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : vintc_pkg

// ### design/vintc_arb_if.sv
// Carrier between the register core and the slot arbiter.
// Assumes both ends share one clock; the arbiter is purely combinational.
interface vintc_arb_if;
  logic [vintc_pkg::NUM_SLOT-1:0] slot_hit;
  logic win_valid;
  logic [vintc_pkg::SLOT_W-1:0] win_slot;
  modport arb (input slot_hit, output win_valid, output win_slot);
  modport ctl (output slot_hit, input win_valid, input win_slot);
endinterface : vintc_arb_if

// ### design/vintc_slot_arb.sv
// Fixed priority arbiter over the vectored slots.
// Assumes slot_hit is already qualified by enable and class.
module vintc_slot_arb (
  vintc_arb_if.arb arb
);

  //----------------------------------------------------------------------
  // Lowest requesting slot wins
  //----------------------------------------------------------------------
  always_comb begin
    arb.win_valid = 1'b0;
    arb.win_slot = '0;
    for (int i = vintc_pkg::NUM_SLOT - 1; i >= 0; i--) begin
      if (arb.slot_hit[i]) begin
        arb.win_valid = 1'b1;
        arb.win_slot = i[vintc_pkg::SLOT_W-1:0];
      end
    end
  end

endmodule : vintc_slot_arb

// ### design/vintc_top.sv
// Vectored interrupt unit: source gathering, classing, vector select and
// an AHB-Lite register slave.
// Assumes peripheral flags are synchronous to hclk and active high.
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
module vintc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic watchdog_irq_flag,
  input wire logic debug_comm_receive_req,
  input wire logic debug_comm_transmit_req,
  input wire logic [3:0] timer0_match_flag,
  input wire logic [2:0] timer0_capture_flag,
  input wire logic [3:0] timer1_match_flag,
  input wire logic [3:0] timer1_capture_flag,
  input wire logic [1:0] line_status_flag,
  input wire logic [1:0] transmitter_empty_flag,
  input wire logic [1:0] receive_data_available_flag,
  input wire logic [1:0] character_timeout_flag,
  input wire logic [1:0] autobaud_timeout_flag,
  input wire logic [1:0] autobaud_end_flag,
  input wire logic modem_status_flag,
  input wire logic [6:0] pwm_match_flag,
  input wire logic twi_state_change_flag,
  input wire logic serial_transfer_done_flag,
  input wire logic serial_mode_fault_flag,
  input wire logic sync_tx_raw_flag,
  input wire logic sync_rx_raw_flag,
  input wire logic sync_rx_timeout_raw_flag,
  input wire logic sync_overrun_raw_flag,
  input wire logic pll_lock_flag,
  input wire logic rtc_increment_flag,
  input wire logic rtc_alarm_flag,
  input wire logic external_irq_0,
  input wire logic external_irq_1,
  input wire logic external_irq_2,
  output logic fiq_req,
  output logic irq_req
);

  localparam int NS = vintc_pkg::NUM_SRC;
  localparam int NV = vintc_pkg::NUM_SLOT;

  //----------------------------------------------------------------------
  // Storage
  //----------------------------------------------------------------------
  logic [NS-1:0] class_reg;
  logic [NS-1:0] enable_reg;
  logic [NS-1:0] soft_reg;
  logic [31:0] default_reg;
  logic [31:0] vect_reg;
  logic [31:0] slot_addr_reg [NV];
  logic [NV-1:0] slot_en_reg;
  logic [vintc_pkg::SRC_W-1:0] slot_src_reg [NV];
  logic [11:0] ap_addr_reg;
  logic ap_write_reg;
  logic ap_read_reg;
  logic [31:0] rd_value;

  logic [NS-1:0] hw_src;
  logic [NS-1:0] src;
  logic [NS-1:0] fast_act;
  logic [NS-1:0] norm_act;
  logic ap_take;

  vintc_arb_if arb_bus ();

  vintc_slot_arb u_arb (
    .arb(arb_bus)
  );

  //----------------------------------------------------------------------
  // Source gathering
  //----------------------------------------------------------------------
  always_comb begin
    hw_src = '0;
    hw_src[vintc_pkg::CH_WDOG] = watchdog_irq_flag;
    hw_src[vintc_pkg::CH_SOFT] = 1'b0;
    hw_src[vintc_pkg::CH_DBG_RX] = debug_comm_receive_req;
    hw_src[vintc_pkg::CH_DBG_TX] = debug_comm_transmit_req;
    hw_src[vintc_pkg::CH_TIMER0] = |timer0_match_flag
                                 | |timer0_capture_flag;
    hw_src[vintc_pkg::CH_TIMER1] = |timer1_match_flag
                                 | |timer1_capture_flag;
    hw_src[vintc_pkg::CH_UART0] = line_status_flag[0]
                                | transmitter_empty_flag[0]
                                | receive_data_available_flag[0]
                                | character_timeout_flag[0]
                                | autobaud_timeout_flag[0]
                                | autobaud_end_flag[0];
    hw_src[vintc_pkg::CH_UART1] = line_status_flag[1]
                                | transmitter_empty_flag[1]
                                | receive_data_available_flag[1]
                                | character_timeout_flag[1]
                                | autobaud_timeout_flag[1]
                                | autobaud_end_flag[1]
                                | modem_status_flag;
    hw_src[vintc_pkg::CH_PWM] = |pwm_match_flag;
    hw_src[vintc_pkg::CH_TWI] = twi_state_change_flag;
    hw_src[vintc_pkg::CH_SSER] = serial_transfer_done_flag
                               | serial_mode_fault_flag
                               | sync_tx_raw_flag
                               | sync_rx_raw_flag
                               | sync_rx_timeout_raw_flag
                               | sync_overrun_raw_flag;
    hw_src[vintc_pkg::CH_RSVD] = 1'b0;
    hw_src[vintc_pkg::CH_PLL] = pll_lock_flag;
    hw_src[vintc_pkg::CH_RTC] = rtc_increment_flag
                              | rtc_alarm_flag;
    hw_src[vintc_pkg::CH_EXT0] = external_irq_0;
    hw_src[vintc_pkg::CH_EXT1] = external_irq_1;
    hw_src[vintc_pkg::CH_EXT2] = external_irq_2;
  end

  //----------------------------------------------------------------------
  // Classing
  //----------------------------------------------------------------------
  assign src = hw_src | soft_reg;
  assign fast_act = src & enable_reg & class_reg;
  assign norm_act = src & enable_reg & ~class_reg;

  always_comb begin
    for (int i = 0; i < NV; i++) begin
      arb_bus.slot_hit[i] = slot_en_reg[i]
                          & norm_act[slot_src_reg[i]];
    end
  end

  //----------------------------------------------------------------------
  // Outputs to the core
  //----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fiq_req <= 1'b0;
      irq_req <= 1'b0;
    end else begin
      fiq_req <= |fast_act;
      irq_req <= |norm_act;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vect_reg <= vintc_pkg::RST_WORD;
    end else if (arb_bus.win_valid) begin
      vect_reg <= slot_addr_reg[arb_bus.win_slot];
    end else begin
      vect_reg <= default_reg;
    end
  end

  //----------------------------------------------------------------------
  // Bus address phase
  //----------------------------------------------------------------------
  assign ap_take = hsel && hready && htrans == vintc_pkg::HTRANS_NONSEQ;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_addr_reg <= '0;
      ap_write_reg <= 1'b0;
      ap_read_reg <= 1'b0;
    end else begin
      ap_write_reg <= ap_take && hwrite;
      ap_read_reg <= ap_take && !hwrite;
      if (ap_take) begin
        ap_addr_reg <= haddr[11:0];
      end
    end
  end

  //----------------------------------------------------------------------
  // Read mux
  //----------------------------------------------------------------------
  localparam int SLOT_IDX_W = vintc_pkg::SLOT_W;

  function automatic logic [SLOT_IDX_W-1:0] slot_of(
    input logic [11:0] a
  );
    slot_of = a[5:2];
  endfunction : slot_of

  always_comb begin
    rd_value = vintc_pkg::RST_WORD;
    unique case (ap_addr_reg[11:8])
      vintc_pkg::PAGE_SLOT_ADDR: begin
        if (ap_addr_reg[7:6] == 2'h0) begin
          rd_value = slot_addr_reg[slot_of(ap_addr_reg)];
        end
      end
      vintc_pkg::PAGE_SLOT_CTRL: begin
        if (ap_addr_reg[7:6] == 2'h0) begin
          rd_value[vintc_pkg::CTRL_EN_BIT] =
            slot_en_reg[slot_of(ap_addr_reg)];
          rd_value[vintc_pkg::CTRL_SRC_LSB +: vintc_pkg::SRC_W] =
            slot_src_reg[slot_of(ap_addr_reg)];
        end
      end
      4'h0: begin
        unique case (ap_addr_reg[7:0])
          vintc_pkg::OFS_NORM_STAT[7:0]: rd_value = norm_act;
          vintc_pkg::OFS_FAST_STAT[7:0]: rd_value = fast_act;
          vintc_pkg::OFS_RAW_STAT[7:0]: rd_value = src;
          vintc_pkg::OFS_CLASS[7:0]: rd_value = class_reg;
          vintc_pkg::OFS_ENABLE[7:0]: rd_value = enable_reg;
          vintc_pkg::OFS_SOFT[7:0]: rd_value = soft_reg;
          vintc_pkg::OFS_VECT[7:0]: rd_value = vect_reg;
          vintc_pkg::OFS_DEFAULT[7:0]: rd_value = default_reg;
          default: rd_value = vintc_pkg::RST_WORD;
        endcase
      end
      default: rd_value = vintc_pkg::RST_WORD;
    endcase
  end

  //----------------------------------------------------------------------
  // Bus data phase
  //----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= vintc_pkg::RST_WORD;
      hreadyout <= 1'b1;
      hresp <= vintc_pkg::HRESP_OKAY;
    end else begin
      hresp <= vintc_pkg::HRESP_OKAY;
      if (ap_take && !hwrite) begin
        hreadyout <= 1'b0;
      end else begin
        hreadyout <= 1'b1;
      end
      if (ap_read_reg) begin
        hrdata <= rd_value;
      end
    end
  end

  //----------------------------------------------------------------------
  // Register writes
  //----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      class_reg <= '0;
      enable_reg <= '0;
      soft_reg <= '0;
      default_reg <= vintc_pkg::RST_WORD;
    end else if (ap_write_reg && ap_addr_reg[11:8] == 4'h0) begin
      unique case (ap_addr_reg[7:0])
        vintc_pkg::OFS_CLASS[7:0]: class_reg <= hwdata;
        vintc_pkg::OFS_ENABLE[7:0]: enable_reg <= hwdata;
        vintc_pkg::OFS_SOFT[7:0]: soft_reg <= hwdata;
        vintc_pkg::OFS_DEFAULT[7:0]: default_reg <= hwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_en_reg <= '0;
      for (int i = 0; i < NV; i++) begin
        slot_addr_reg[i] <= vintc_pkg::RST_WORD;
        slot_src_reg[i] <= '0;
      end
    end else if (ap_write_reg && ap_addr_reg[7:6] == 2'h0) begin
      if (ap_addr_reg[11:8] == vintc_pkg::PAGE_SLOT_ADDR) begin
        slot_addr_reg[slot_of(ap_addr_reg)] <= hwdata;
      end
      if (ap_addr_reg[11:8] == vintc_pkg::PAGE_SLOT_CTRL) begin
        slot_en_reg[slot_of(ap_addr_reg)] <=
          hwdata[vintc_pkg::CTRL_EN_BIT];
        slot_src_reg[slot_of(ap_addr_reg)] <=
          hwdata[vintc_pkg::CTRL_SRC_LSB +: vintc_pkg::SRC_W];
      end
    end
  end

  //----------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------
  class_excl_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (fast_act & norm_act) == '0)
    else $error("line active in two classes");

  fiq_merge_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $onehot(fast_act) || $countones(fast_act) > 1 |=> fiq_req)
    else $error("fast requests not merged");

  fiq_quiet_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fast_act == '0 |=> !fiq_req)
    else $error("fast line without fast source");

  slot_prio_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    arb_bus.win_valid |-> arb_bus.slot_hit[arb_bus.win_slot] &&
      (arb_bus.slot_hit & ((16'h0001 << arb_bus.win_slot) - 16'h0001))
      == '0)
    else $error("lower slot lost arbitration");

  irq_merge_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    norm_act != '0 |=> irq_req)
    else $error("normal line not raised");

  vect_sel_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    arb_bus.win_valid |=>
      vect_reg == $past(slot_addr_reg[arb_bus.win_slot]))
    else $error("wrong vector address");

  vect_dflt_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !arb_bus.win_valid |=> vect_reg == $past(default_reg))
    else $error("default address not given");

  line_off_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    enable_reg == '0 |=> !fiq_req && !irq_req)
    else $error("disabled line reached core");

  ch_quiet_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !hw_src[vintc_pkg::CH_RSVD] && !hw_src[vintc_pkg::CH_SOFT])
    else $error("idle channel asserted");

  read_wait_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ap_take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

endmodule : vintc_top

// ### tb/vintc_core_model.sv
// Stand-in for the processor core: watches the fast and normal lines.
// Assumes both lines are registered levels in the hclk domain.
module vintc_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fiq_in,
  input wire logic irq_in,
  output logic [1:0] mode
);
  timeunit 1ns;
  timeprecision 1ps;
  //----------------------------------------------------------------------
  // Taken mode: 2 fast, 1 normal, 0 idle
  //----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= 2'h0;
    end else begin
      mode <= fiq_in ? 2'h2 : {1'b0, irq_in};
    end
  end
endmodule : vintc_core_model

// ### tb/vectored_interrupt_controller_tb.sv
// Self-checking bench for the vectored interrupt unit.
// Assumes the design package, interface and modules are compiled first.
module vectored_interrupt_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic fiq_req, irq_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, mode;
  logic [2:0] hsize;
  logic [50:0] fl;
  int error_cnt, checks_done;
  // Rows: first flag, last flag, channel they reach
  int rows [15][3] = '{'{0, 0, 0}, '{1, 1, 2}, '{2, 2, 3}, '{3, 9, 4},
    '{10, 17, 5}, '{18, 23, 6}, '{24, 30, 7}, '{31, 37, 8}, '{38, 38, 9},
    '{39, 44, 10}, '{45, 45, 12}, '{46, 47, 13}, '{48, 48, 14},
    '{49, 49, 15}, '{50, 50, 16}};
  // Slot number, channel
  int slots [4][2] = '{'{0, 15}, '{3, 14}, '{9, 4}, '{15, 9}};
  logic [50:0] vin [7] = '{51'h8, 51'h1_0000_0000_0008, 51'h3_0000_0000_0008,
    51'h40_0000_0008, 51'h40_0000_0000, 51'h4_0000_0000_0000,
    51'h4_0000_0000_0008};
  logic [31:0] vexp [7] = '{32'ha000_0009, 32'ha000_0003, 32'ha000_0000,
    32'ha000_0009, 32'ha000_000f, 32'h5555_0000, 32'ha000_0009};

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  assign hready = hreadyout;

  vintc_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .watchdog_irq_flag(fl[0]), .debug_comm_receive_req(fl[1]),
    .debug_comm_transmit_req(fl[2]), .timer0_match_flag(fl[6:3]),
    .timer0_capture_flag(fl[9:7]), .timer1_match_flag(fl[13:10]),
    .timer1_capture_flag(fl[17:14]), .line_status_flag({fl[24], fl[18]}),
    .transmitter_empty_flag({fl[25], fl[19]}),
    .receive_data_available_flag({fl[26], fl[20]}),
    .character_timeout_flag({fl[27], fl[21]}),
    .autobaud_timeout_flag({fl[28], fl[22]}),
    .autobaud_end_flag({fl[29], fl[23]}), .modem_status_flag(fl[30]),
    .pwm_match_flag(fl[37:31]), .twi_state_change_flag(fl[38]),
    .serial_transfer_done_flag(fl[39]), .serial_mode_fault_flag(fl[40]),
    .sync_tx_raw_flag(fl[41]), .sync_rx_raw_flag(fl[42]),
    .sync_rx_timeout_raw_flag(fl[43]), .sync_overrun_raw_flag(fl[44]),
    .pll_lock_flag(fl[45]), .rtc_increment_flag(fl[46]),
    .rtc_alarm_flag(fl[47]), .external_irq_0(fl[48]),
    .external_irq_1(fl[49]), .external_irq_2(fl[50]),
    .fiq_req(fiq_req), .irq_req(irq_req)
  );

  vintc_core_model core (
    .clk(hclk), .rst_n(hresetn), .fiq_in(fiq_req), .irq_in(irq_req),
    .mode(mode)
  );

  //----------------------------------------------------------------------
  // Compare, bus and closing tasks
  //----------------------------------------------------------------------
  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input logic exp, input logic got);
    chk_word({31'h0, exp}, {31'h0, got});
  endtask : chk_bit

  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= vintc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 128);
    rd = hrdata;
    chk_bit(vintc_pkg::HRESP_OKAY, hresp);
    chk_word(w ? 32'h2 : 32'h3, n);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_word(exp, rd);
  endtask : rdc

  task automatic settle;
    repeat (3) @(posedge hclk);
  endtask : settle

  task automatic give_verdict;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  //----------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fl = 51'h0;
    error_cnt = 0;
    checks_done = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(vintc_pkg::OFS_CLASS, vintc_pkg::RST_WORD);
    rdc(vintc_pkg::OFS_ENABLE, vintc_pkg::RST_WORD);
    rdc(vintc_pkg::OFS_DEFAULT, vintc_pkg::RST_WORD);
    // Source table: each flag alone reaches its own channel
    wr(vintc_pkg::OFS_ENABLE, 32'hffff_ffff);
    for (int r = 0; r < 15; r++) begin
      for (int b = rows[r][0]; b <= rows[r][1]; b++) begin
        fl <= 51'h1 << b;
        settle();
        chk_bit(1'b1, irq_req);
        chk_bit(1'b0, fiq_req);
        chk_word(32'h1, {30'h0, mode});
        rdc(vintc_pkg::OFS_RAW_STAT, 32'h1 << rows[r][2]);
        rdc(vintc_pkg::OFS_NORM_STAT, 32'h1 << rows[r][2]);
      end
    end
    fl <= {51{1'b1}};
    settle();
    rdc(vintc_pkg::OFS_RAW_STAT, 32'h0001_f7fd);
    $display("test source table done");
    fl <= 51'h0;
    wr(vintc_pkg::OFS_SOFT, 32'h2);
    settle();
    rdc(vintc_pkg::OFS_RAW_STAT, 32'h2);
    chk_bit(1'b1, irq_req);
    wr(vintc_pkg::OFS_SOFT, 32'h0);
    $display("test soft channel done");
    // Fast class merges, identifies, and ranks first
    wr(vintc_pkg::OFS_CLASS, 32'h4010);
    fl <= 51'h1_0000_0000_0008;
    settle();
    chk_bit(1'b1, fiq_req);
    chk_bit(1'b0, irq_req);
    rdc(vintc_pkg::OFS_FAST_STAT, 32'h4010);
    rdc(vintc_pkg::OFS_NORM_STAT, 32'h0);
    wr(vintc_pkg::OFS_CLASS, 32'h10);
    settle();
    chk_bit(1'b1, irq_req);
    chk_word(32'h2, {30'h0, mode});
    rdc(vintc_pkg::OFS_NORM_STAT, 32'h4000);
    wr(vintc_pkg::OFS_CLASS, 32'h0);
    $display("test fast class done");
    // Vectored slots, priority and default address
    wr(vintc_pkg::OFS_DEFAULT, 32'h5555_0000);
    rdc(vintc_pkg::OFS_DEFAULT, 32'h5555_0000);
    for (int s = 0; s < 4; s++) begin
      wr({vintc_pkg::PAGE_SLOT_ADDR, 2'h0, slots[s][0][3:0], 2'h0},
        32'ha000_0000 + slots[s][0]);
      wr({vintc_pkg::PAGE_SLOT_CTRL, 2'h0, slots[s][0][3:0], 2'h0},
        32'h20 | slots[s][1]);
    end
    for (int i = 0; i < 7; i++) begin
      fl <= vin[i];
      settle();
      rdc(vintc_pkg::OFS_VECT, vexp[i]);
      chk_bit(1'b1, irq_req);
    end
    wr(vintc_pkg::OFS_CLASS, 32'h8000);
    fl <= 51'h2_0000_0000_0008;
    settle();
    rdc(vintc_pkg::OFS_VECT, 32'ha000_0009);
    chk_bit(1'b1, fiq_req);
    $display("test vectored slots done");
    // Disabled line is ignored by both lines, normal status and vector
    wr(vintc_pkg::OFS_CLASS, 32'h0);
    wr(vintc_pkg::OFS_ENABLE, 32'hffff_bfff);
    fl <= 51'h1_0000_0000_0000;
    settle();
    chk_bit(1'b0, irq_req);
    rdc(vintc_pkg::OFS_NORM_STAT, 32'h0);
    rdc(vintc_pkg::OFS_VECT, 32'h5555_0000);
    wr(vintc_pkg::OFS_CLASS, 32'h4000);
    settle();
    chk_bit(1'b0, fiq_req);
    $display("test disabled line done");
    // Unmapped and read-only places
    wr(12'h300, 32'hffff_ffff);
    rdc(12'h300, 32'h0);
    wr(vintc_pkg::OFS_RAW_STAT, 32'hffff_ffff);
    rdc(vintc_pkg::OFS_RAW_STAT, 32'h4000);
    $display("test refusals done");
    // Reset in mid-run
    wr(vintc_pkg::OFS_ENABLE, 32'hffff_ffff);
    wr(vintc_pkg::OFS_CLASS, 32'h0);
    settle();
    chk_bit(1'b1, irq_req);
    hresetn <= 1'b0;
    @(posedge hclk);
    chk_bit(1'b0, irq_req);
    chk_word(32'h0, {30'h0, mode});
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(vintc_pkg::OFS_ENABLE, vintc_pkg::RST_WORD);
    chk_bit(1'b0, irq_req);
    $display("test mid-run reset done");
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    give_verdict();
  end
endmodule : vectored_interrupt_controller_tb
